// ---- common/hsail_pkg.sv ----
// constants shared by the hub strap capture and indicator logic
// Notes on behaviour
// [R01] at reset release the level of the shared serial-clock pin is latched as config_select_bit0.
// [R02] at reset release the highspeed_indicator pin level is latched as config_select_bit1.
// [R03] with the fixed-port strap enabled, serial-data and suspend-indicator pins are latched.
// [R04] fixed-port code 00 means all removable, 01 port 1 fixed, 10 ports 1 and 2 fixed.
// [R05] highspeed_indicator is active high when config_select_bit1 is 0, else active low.
// [R06] highspeed_indicator is asserted at high speed upstream and negated at full speed.
// [R07] the system holds the reset pin low at least 1 us once all supplies are nominal.
// [R08] the system supplies a 24 MHz reference by crystal or external clock; the testbench drives sys_clk at 100 MHz (10 ns period).
// [R09] suspend_indicator is active high for code 00, active low for 01, active high for 10.
// [R10] suspend_indicator is asserted only while configured and not suspended.
// [R11] latched strap values stay fixed until the next reset, whatever the pins do later.
package hsail_pkg;
	// register map, byte addresses within the decoded window
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	// control register fields
	localparam int CTRL_LINK_HS = 0;
	localparam int CTRL_CONFIGURED = 1;
	localparam int CTRL_SUSPENDED = 2;
	localparam int CTRL_W = 3;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// status register fields
	localparam int ST_CFG0 = 0;
	localparam int ST_CFG1 = 1;
	localparam int ST_FIXED_HI = 2;
	localparam int ST_FIXED_LO = 3;
	localparam int ST_VALID = 4;
	localparam int ST_PORT1_FIXED = 5;
	localparam int ST_PORT2_FIXED = 6;
	localparam int ST_HS_LOW = 7;
	localparam int ST_SUSP_LOW = 8;
	localparam int ST_STRAP_EN = 9;
	localparam int ST_W = 10;
	// synchronised pin vector layout
	localparam int PIN_CFG0 = 0;
	localparam int PIN_FIXED_HI = 1;
	localparam int PIN_CFG1 = 2;
	localparam int PIN_FIXED_LO = 3;
	localparam int PIN_STRAP_EN = 4;
	localparam int PIN_W = 5;
	// fixed-port strap codes
	localparam logic [1:0] FIXED_NONE = 2'h0;
	localparam logic [1:0] FIXED_P1 = 2'h1;
	localparam logic [1:0] FIXED_P12 = 2'h2;
	// ahb-lite encodings
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;
endpackage

// ---- logic/hsail_sync.sv ----
// two-flop synchronisers for the strap and indicator pins
`timescale 1ns/1ns
module hsail_sync (
	// clock
	input wire logic sys_clk,
	// raw pins and synchronised copy
	input wire logic [hsail_pkg::PIN_W-1:0] din,
	output logic [hsail_pkg::PIN_W-1:0] dout
);
	logic [hsail_pkg::PIN_W-1:0] meta_q;
	logic [hsail_pkg::PIN_W-1:0] sync_q;

	// no reset, so pins are tracked while the chip is still in reset
	genvar i;
	for (i = 0; i < hsail_pkg::PIN_W; i++) begin : g_bit
		always_ff @(posedge sys_clk) begin
			meta_q[i] <= din[i];
			sync_q[i] <= meta_q[i];
		end
	end

	assign dout = sync_q;
endmodule

// ---- logic/hsail_top.sv ----
// strap capture at reset release, indicator drivers and ahb-lite registers
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
module hsail_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// shared serial pins, strap inputs only
	input wire logic scl_pin_in,
	input wire logic sda_pin_in,
	// highspeed_indicator pin
	input wire logic highspeed_indicator_in,
	output logic highspeed_indicator_out,
	output logic highspeed_indicator_oe,
	// suspend_indicator pin
	input wire logic suspend_indicator_in,
	output logic suspend_indicator_out,
	output logic suspend_indicator_oe,
	// fixed-port strap enable from configuration
	input wire logic strap_en_in
);
	logic rst_s1_q;
	logic rst_s2_q;
	logic rst_sync_n;
	logic [hsail_pkg::PIN_W-1:0] pin_raw;
	logic [hsail_pkg::PIN_W-1:0] pin_s;
	logic captured_q;
	logic cfg0_q;
	logic cfg1_q;
	logic strap_en_q;
	logic [1:0] fixed_q;
	logic [1:0] fixed_sample;
	logic capture_now;
	logic [1:0] port_fixed;
	logic susp_low;
	logic [hsail_pkg::CTRL_W-1:0] ctrl_q;
	logic [hsail_pkg::CTRL_W-1:0] ctrl_cur;
	logic wr_pend_q;
	logic [hsail_pkg::ADDR_W-1:0] wr_addr_q;
	logic ahb_take;
	logic ctrl_wr;
	logic [31:0] status_word;
	logic [31:0] ctrl_word;
	logic [31:0] rd_value;
	logic [31:0] hrdata_q;
	logic hs_assert;
	logic susp_assert;
	logic hs_out_d;
	logic susp_out_d;
	logic hs_out_q;
	logic susp_out_q;
	logic oe_q;

	// reset: asserted at once, released through two flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'h0;
			rst_s2_q <= 1'h0;
		end else begin
			rst_s1_q <= 1'h1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_sync_n = rst_s2_q;

	// pins gathered for the synchroniser
	assign pin_raw[hsail_pkg::PIN_CFG0] = scl_pin_in;
	assign pin_raw[hsail_pkg::PIN_FIXED_HI] = sda_pin_in;
	assign pin_raw[hsail_pkg::PIN_CFG1] = highspeed_indicator_in;
	assign pin_raw[hsail_pkg::PIN_FIXED_LO] = suspend_indicator_in;
	assign pin_raw[hsail_pkg::PIN_STRAP_EN] = strap_en_in;

	hsail_sync u_sync (
		.sys_clk(sys_clk),
		.din(pin_raw),
		.dout(pin_s)
	);

	// straps sampled on the first edge after the internal release
	assign capture_now = !captured_q;
	assign fixed_sample = pin_s[hsail_pkg::PIN_STRAP_EN] ?
		{pin_s[hsail_pkg::PIN_FIXED_HI], pin_s[hsail_pkg::PIN_FIXED_LO]} :
		hsail_pkg::FIXED_NONE; // [R03]

	// sync lags the pin two cycles, which still sees the level at pin release
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			captured_q <= 1'h0;
			cfg0_q <= 1'h0;
			cfg1_q <= 1'h0;
			strap_en_q <= 1'h0;
			fixed_q <= hsail_pkg::FIXED_NONE;
		end else if (capture_now) begin // [R11]
			captured_q <= 1'h1;
			cfg0_q <= pin_s[hsail_pkg::PIN_CFG0]; // [R01]
			cfg1_q <= pin_s[hsail_pkg::PIN_CFG1]; // [R02]
			strap_en_q <= pin_s[hsail_pkg::PIN_STRAP_EN];
			fixed_q <= fixed_sample; // [R03]
		end
	end

	// fixed-port decode; unlisted code 11 is taken as both ports fixed
	assign port_fixed[0] = fixed_q != hsail_pkg::FIXED_NONE; // [R04]
	assign port_fixed[1] = fixed_q[1]; // [R04]
	assign susp_low = fixed_q == hsail_pkg::FIXED_P1; // [R09]

	// ahb-lite address phase and write decode
	assign ahb_take = hsel && htrans[hsail_pkg::HTRANS_ACTIVE_BIT] && hready;
	assign ctrl_wr = wr_pend_q && (wr_addr_q == hsail_pkg::REG_CTRL);
	assign ctrl_cur = ctrl_wr ? hwdata[hsail_pkg::CTRL_W-1:0] : ctrl_q;

	// read words; a read right after a write sees the new control value
	assign ctrl_word = {{(32 - hsail_pkg::CTRL_W){1'h0}}, ctrl_cur};
	assign status_word[hsail_pkg::ST_CFG0] = cfg0_q;
	assign status_word[hsail_pkg::ST_CFG1] = cfg1_q;
	assign status_word[hsail_pkg::ST_FIXED_HI] = fixed_q[1];
	assign status_word[hsail_pkg::ST_FIXED_LO] = fixed_q[0];
	assign status_word[hsail_pkg::ST_VALID] = captured_q;
	assign status_word[hsail_pkg::ST_PORT1_FIXED] = port_fixed[0];
	assign status_word[hsail_pkg::ST_PORT2_FIXED] = port_fixed[1];
	assign status_word[hsail_pkg::ST_HS_LOW] = cfg1_q;
	assign status_word[hsail_pkg::ST_SUSP_LOW] = susp_low;
	assign status_word[hsail_pkg::ST_STRAP_EN] = strap_en_q;
	assign status_word[31:hsail_pkg::ST_W] = '0;
	assign rd_value = (haddr[hsail_pkg::ADDR_W-1:0] == hsail_pkg::REG_CTRL) ? ctrl_word :
		(haddr[hsail_pkg::ADDR_W-1:0] == hsail_pkg::REG_STATUS) ? status_word : 32'h0;

	// data phase tracking; only whole-word writes are honoured
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wr_pend_q <= 1'h0;
			wr_addr_q <= '0;
		end else if (hready) begin
			wr_pend_q <= ahb_take && hwrite && (hsize == hsail_pkg::HSIZE_WORD);
			wr_addr_q <= haddr[hsail_pkg::ADDR_W-1:0];
		end
	end

	// control register and registered read data
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_q <= hsail_pkg::CTRL_RESET;
			hrdata_q <= 32'h0;
		end else begin
			ctrl_q <= ctrl_cur;
			if (ahb_take && !hwrite) begin
				hrdata_q <= rd_value;
			end
		end
	end

	// zero wait states, never an error
	assign hreadyout = 1'h1;
	assign hresp = hsail_pkg::HRESP_OKAY;
	assign hrdata = hrdata_q;

	// indicator levels; polarity follows the latched straps
	assign hs_assert = ctrl_q[hsail_pkg::CTRL_LINK_HS]; // [R06]
	assign susp_assert = ctrl_q[hsail_pkg::CTRL_CONFIGURED] &&
		!ctrl_q[hsail_pkg::CTRL_SUSPENDED]; // [R10]
	assign hs_out_d = captured_q && (hs_assert ^ cfg1_q); // [R05]
	assign susp_out_d = captured_q && (susp_assert ^ susp_low); // [R09]

	// pins float until the straps are in, so the board resistors set them
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			hs_out_q <= 1'h0;
			susp_out_q <= 1'h0;
			oe_q <= 1'h0;
		end else begin
			hs_out_q <= hs_out_d;
			susp_out_q <= susp_out_d;
			oe_q <= captured_q;
		end
	end
	assign highspeed_indicator_out = hs_out_q;
	assign suspend_indicator_out = susp_out_q;
	assign highspeed_indicator_oe = oe_q;
	assign suspend_indicator_oe = oe_q;

	// checks
	chk_cfg0_latch: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [R01]
		$rose(captured_q) |-> cfg0_q == $past(pin_s[hsail_pkg::PIN_CFG0]))
		else $error("config_select_bit0 not latched from scl pin");
	chk_cfg1_latch: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [R02]
		$rose(captured_q) |-> cfg1_q == $past(pin_s[hsail_pkg::PIN_CFG1]))
		else $error("config_select_bit1 not latched from indicator pin");
	chk_fixed_latch: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [R03]
		$rose(captured_q) |-> fixed_q == ($past(pin_s[hsail_pkg::PIN_STRAP_EN]) ?
		{$past(pin_s[hsail_pkg::PIN_FIXED_HI]), $past(pin_s[hsail_pkg::PIN_FIXED_LO])} :
		hsail_pkg::FIXED_NONE))
		else $error("fixed-port strap latched wrongly");
	chk_fixed_decode: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [R04]
		ahb_take && !hwrite && haddr[hsail_pkg::ADDR_W-1:0] == hsail_pkg::REG_STATUS
		&& fixed_q == hsail_pkg::FIXED_P12 |=>
		hrdata[hsail_pkg::ST_PORT1_FIXED] && hrdata[hsail_pkg::ST_PORT2_FIXED])
		else $error("code 10 does not report both ports fixed");
	chk_hs_polarity: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [R05]
		captured_q && cfg1_q && !hs_assert |=> highspeed_indicator_out && highspeed_indicator_oe)
		else $error("active-low speed indicator not idle high");
	chk_hs_speed: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [R06]
		captured_q ##1 captured_q |-> highspeed_indicator_out == ($past(hs_assert) ^ cfg1_q))
		else $error("speed indicator does not follow link speed");
	chk_susp_polarity: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [R09]
		captured_q && fixed_q == hsail_pkg::FIXED_P1 && susp_assert |=> !suspend_indicator_out)
		else $error("suspend indicator not active low for code 01");
	chk_susp_state: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [R10]
		captured_q && ctrl_q[hsail_pkg::CTRL_SUSPENDED] |=> suspend_indicator_out == susp_low)
		else $error("suspend indicator asserted while suspended");
	chk_straps_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [R11]
		captured_q |=> $stable(cfg0_q) && $stable(cfg1_q) && $stable(fixed_q))
		else $error("latched straps changed after capture");
	chk_pins_float: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // [R11]
		!captured_q |=> !highspeed_indicator_oe && !suspend_indicator_oe)
		else $error("indicator driven before straps were latched");
endmodule

// ---- test/hsail_board_model.sv ----
// board model: strap resistors on the shared pins and the indicator leds
`timescale 1ns/1ns
module hsail_board_model (
	// strap resistor levels {cfg1, cfg0, hi, lo}
	input wire logic [3:0] straps,
	// indicator drivers from the hub
	input wire logic hs_out,
	input wire logic hs_oe,
	input wire logic su_out,
	input wire logic su_oe,
	// resolved pin levels
	output logic scl,
	output logic sda,
	output logic hs_pin,
	output logic su_pin
);
	// serial pins only see their strap resistor, nothing here drives them
	assign scl = straps[2];
	assign sda = straps[1];
	// a driving hub overrides the weak strap resistor on each indicator pin
	assign hs_pin = hs_oe ? hs_out : straps[3];
	assign su_pin = su_oe ? su_out : straps[0];
endmodule

// ---- test/testbench.sv ----
// self-checking bench for strap capture, indicator drive and registers
`timescale 1ns/1ns
module testbench;
	logic sys_clk, rst_n, hsel, hwrite, hready, hresp, strap_en;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hs_out, hs_oe, su_out, su_oe, scl, sda, hs_pin, su_pin;
	logic [3:0] straps;
	int num_errors, checks_done, cyc;
	hsail_top i_hsail_top (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .scl_pin_in(scl),
		.sda_pin_in(sda), .highspeed_indicator_in(hs_pin), .highspeed_indicator_out(hs_out), .highspeed_indicator_oe(hs_oe),
		.suspend_indicator_in(su_pin), .suspend_indicator_out(su_out), .suspend_indicator_oe(su_oe),
		.strap_en_in(strap_en));
	hsail_board_model i_hsail_board_model (.straps(straps), .hs_out(hs_out), .hs_oe(hs_oe),
		.su_out(su_out), .su_oe(su_oe), .scl(scl), .sda(sda), .hs_pin(hs_pin),
		.su_pin(su_pin));
	// free-running reference for the hub, 10 ns period
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// the whole run needs about 800 cycles, so this only trips on a hang
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_sim();
		end
	end
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one single ahb-lite transfer at the current hsize; read data lands in rd
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata;
		// the slave never signals an error
		cmp("hresp", 32'(hsail_pkg::HRESP_OKAY), 32'(hresp));
	endtask
	// reset with given straps, check latched status, indicators and stability
	task automatic t_strap(input logic [3:0] s, input logic en);
		logic [1:0] code;
		logic [31:0] exp, mask;
		code = en ? s[1:0] : 2'h0;
		// raw hi/lo bits are not meaningful while the strap is disabled
		mask = en ? 32'hffffffff : 32'hfffffff3;
		exp = {22'h0, en, code == 2'h1, s[3], code[1], code != 2'h0, 1'b1, s[0], s[1], s[3], s[2]};
		// step off the edge on which the caller last drove reset
		@(posedge sys_clk);
		straps <= s;
		strap_en <= en;
		rst_n <= 1'b0;
		repeat (100) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		bus(1'b0, 32'h4, 32'h0);
		cmp("status", exp & mask, rd & mask);
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, 32'h0, 32'(c));
			repeat (2) @(posedge sys_clk);
			cmp("hs pin", 32'(c[0] ^ s[3]), 32'(hs_pin));
			cmp("susp pin", 32'((c[1] & !c[2]) ^ (code == 2'h1)), 32'(su_pin));
		end
		// later pin changes must not reach the latched straps
		straps <= ~s;
		strap_en <= !en;
		repeat (4) @(posedge sys_clk);
		bus(1'b0, 32'h4, 32'h0);
		cmp("status held", exp & mask, rd & mask);
		$display("strap test %h en %0d done", s, en);
	endtask
	// read-only status, unmapped address and control read-back
	task automatic t_regs;
		logic [31:0] st;
		bus(1'b0, 32'h4, 32'h0);
		st = rd;
		bus(1'b1, 32'h4, 32'hffffffff);
		bus(1'b0, 32'h4, 32'h0);
		cmp("status ro", st, rd);
		bus(1'b1, 32'h8, 32'hffffffff);
		bus(1'b0, 32'h8, 32'h0);
		cmp("unmapped", 32'h0, rd);
		bus(1'b1, 32'h0, 32'h5);
		bus(1'b0, 32'h0, 32'h0);
		cmp("ctrl", 32'h5, rd);
		// a write narrower than a word must leave control untouched
		hsize <= 3'h0;
		bus(1'b1, 32'h0, 32'h2);
		hsize <= 3'h2;
		bus(1'b0, 32'h0, 32'h0);
		cmp("ctrl byte write", 32'h5, rd);
		$display("register test done");
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		straps = 4'h0;
		strap_en = 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_strap(4'b0000, 1'b1);
		t_strap(4'b1001, 1'b1);
		t_strap(4'b0110, 1'b1);
		t_strap(4'b1100, 1'b1);
		t_strap(4'b1111, 1'b0);
		t_regs();
		end_sim();
	end
endmodule
